// *** reset_ctrl_pkg.sv ***
// Purpose: shared constants and types of the bidirectional reset control block
// Assumes: 50 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   every offset, field position, reset value and timing count lives here
package reset_ctrl_pkg;

  // clock and pin timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int RECOG_PULSE_NS  = 100;
  localparam int SPIKE_PULSE_NS  = 10;
  // least times round up to whole cycles, never below one
  localparam int RECOG_CYCLES    = (RECOG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPIKE_CYCLES_RAW = (SPIKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPIKE_CYCLES    = (SPIKE_CYCLES_RAW < 1) ? 1 : SPIKE_CYCLES_RAW;
  localparam int FILTER_CYCLES   = (RECOG_CYCLES > SPIKE_CYCLES) ? RECOG_CYCLES : SPIKE_CYCLES;
  localparam int FILTER_W        = 4;

  // internal reset sequence length
  localparam int SEQ_CYCLES_DEF  = 1024;
  localparam int SEQ_W           = 16;

  // register byte addresses
  localparam logic [7:0] ADDR_CONFIG  = 8'h00;
  localparam logic [7:0] ADDR_SOURCE  = 8'h04;
  localparam logic [7:0] ADDR_COMMAND = 8'h08;
  localparam logic [7:0] ADDR_STARTUP = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_MASK    = 8'h14;

  // system_config_register fields
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_LOCKED_BIT = 1;
  // reset source flags
  localparam int SRC_LONG_HW_BIT  = 0;
  localparam int SRC_SHORT_HW_BIT = 1;
  localparam int SRC_SW_BIT       = 2;
  localparam int SRC_WDT_BIT      = 3;
  localparam int SRC_W            = 4;
  // command fields
  localparam int CMD_SW_RESET_BIT = 0;
  localparam int CMD_END_OF_INIT_INSTRUCTION_BIT    = 1;
  // startup register fields
  localparam int PORT_W             = 16;
  localparam int BOOT_STRAP_BIT     = 4;
  localparam int STARTUP_BOOT_BIT   = 16;
  // interrupt events
  localparam int EV_RESET_DONE_BIT = 0;
  localparam int EV_INIT_DONE_BIT  = 1;
  localparam int EV_WDT_BIT        = 2;
  localparam int EV_W              = 3;

  // reset values
  localparam logic [EV_W-1:0]   MASK_RESET   = 3'h0;
  localparam logic [SRC_W-1:0]  SRC_RESET    = 4'h1;
  localparam logic [PORT_W-1:0] PORT_RESET   = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_SEQUENCE,
    ST_RELEASE,
    ST_INIT,
    ST_RUN
  } seq_state_type;

endpackage

// *** reset_pin_filter.sv ***
// Purpose: spike filter on the sampled reset pin level
// Assumes: pin level already synchronous to aclk
// Notes:   low must persist FILTER_LEN samples before it counts; high is taken at once
`timescale 1ns/1ps
`default_nettype none
module reset_pin_filter #(
  parameter int FILTER_LEN = reset_ctrl_pkg::FILTER_CYCLES
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin level and filtered result
  input  wire logic pin_level,
  output logic      pin_low
);
  import reset_ctrl_pkg::*;

  typedef struct packed {
    logic [FILTER_W-1:0] low_count;
    logic                pin_low;
  } filt_type;

  filt_type cur;
  filt_type next_cur;

  always_comb begin
    next_cur = cur;
    if (pin_level) begin
      next_cur.low_count = '0;
      next_cur.pin_low   = 1'b0;
    end else if (cur.low_count >= FILTER_W'(FILTER_LEN - 1)) begin
      next_cur.pin_low = 1'b1;
    end else begin
      next_cur.low_count = cur.low_count + FILTER_W'(1);
    end
  end

  // pin idles high through its pull-up, so reset to released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign pin_low = cur.pin_low;

endmodule
`default_nettype wire

// *** bidir_reset_control.sv ***
// Purpose: reset sequencer with optional bidirectional reset pin
// Assumes: pins sampled synchronously to aclk, open-drain partner on the reset line
// Notes:   registers reached over AXI4-Lite; one level interrupt from sticky events
//
// How it works
// - enable bit frozen after end of init
// - every reset clears the enable bit
// - bidir mode reports long hardware reset
// - bidir mode samples startup port always
// - bidir mode boots when strap low
// - short hardware reset stretched to sequence
// - bidir mode pulls pin low during whole sequence
// - enable bit lives in config register
// - indication low until end of init
// - filter spikes, recognise long pulses
`timescale 1ns/1ps
`default_nettype none
module bidir_reset_control #(
  parameter int SEQ_CYCLES = reset_ctrl_pkg::SEQ_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [7:0]                  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // AXI4-Lite write response
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [7:0]                  s_axi_araddr,
  // AXI4-Lite read data
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // reset pin, open drain
  input  wire logic                        reset_input_pin_in,
  output logic                             reset_input_pin_out,
  output logic                             reset_input_pin_oe,
  // reset indication and core reset
  output logic                             reset_indication_output_n,
  output logic                             core_reset_n,
  // startup configuration
  input  wire logic [reset_ctrl_pkg::PORT_W-1:0] startup_config_port,
  output logic                             bootstrap_mode,
  // watchdog request and interrupt
  input  wire logic                        wdt_reset_req,
  output logic                             irq
);
  import reset_ctrl_pkg::*;

  typedef struct packed {
    seq_state_type    state;
    logic [SEQ_W-1:0] seq_count;
    logic             bidir_reset_enable;
    logic             init_locked;
    logic             bidir_active;
    logic             cause_hw;
    logic             cause_sw;
    logic             cause_wdt;
    logic             hw_long;
    logic [SRC_W-1:0] source_flags;
    logic [PORT_W-1:0] startup_config;
    logic             bootstrap_mode;
    logic [EV_W-1:0]  irq_status;
    logic [EV_W-1:0]  irq_mask;
    logic             irq;
    logic             pin_drive;
    logic             core_reset_n;
    logic             reset_indication_n;
    logic             aw_held;
    logic [7:0]       aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } ctrl_type;

  localparam logic [SEQ_W-1:0] SEQ_LAST = SEQ_W'(SEQ_CYCLES - 1);

  ctrl_type cur;
  ctrl_type next_cur;
  logic     pin_low;

  reset_pin_filter #(
    .FILTER_LEN (FILTER_CYCLES)
  ) u_filter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_level (reset_input_pin_in),
    .pin_low   (pin_low)
  );

  // sequencer, register file and bus slave in one next-state process
  always_comb begin
    logic            do_write;
    logic            wr_lane0;
    logic            sw_req;
    logic            end_of_init_instruction_req;
    logic            hw_req;
    logic            trigger;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    do_write  = 1'b0;
    wr_lane0  = 1'b0;
    sw_req    = 1'b0;
    end_of_init_instruction_req = 1'b0;
    hw_req    = 1'b0;
    trigger   = 1'b0;
    ev_set    = '0;
    ev_clr    = '0;
    next_cur  = cur;

    // address and data are taken independently, in either order
    if (s_axi_awvalid && cur.awready) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && cur.wready) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_strb = s_axi_wstrb;
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end

    // the write acts one cycle after both halves are held
    if (cur.aw_held && cur.w_held && !cur.bvalid) begin
      do_write         = 1'b1;
      wr_lane0         = cur.w_strb[0];
      next_cur.aw_held = 1'b0;
      next_cur.w_held  = 1'b0;
      next_cur.bvalid  = 1'b1;
      next_cur.bresp   = RESP_OKAY;
      case (cur.aw_addr)
        ADDR_CONFIG: begin
          if (wr_lane0 && !cur.init_locked) begin
            next_cur.bidir_reset_enable = cur.w_data[CFG_ENABLE_BIT];
          end
        end
        ADDR_COMMAND: begin
          sw_req    = wr_lane0 && cur.w_data[CMD_SW_RESET_BIT];
          end_of_init_instruction_req = wr_lane0 && cur.w_data[CMD_END_OF_INIT_INSTRUCTION_BIT];
        end
        ADDR_STATUS: begin
          if (wr_lane0) begin
            ev_clr = cur.w_data[EV_W-1:0];
          end
        end
        ADDR_MASK: begin
          if (wr_lane0) begin
            next_cur.irq_mask = cur.w_data[EV_W-1:0];
          end
        end
        ADDR_SOURCE, ADDR_STARTUP: begin
          next_cur.bresp = RESP_OKAY;  // read-only, write ignored
        end
        default: begin
          next_cur.bresp = RESP_SLVERR;
        end
      endcase
    end

    // read answers one cycle after the address is taken
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end
    if (s_axi_arvalid && cur.arready) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp  = RESP_OKAY;
      next_cur.rdata  = '0;
      case (s_axi_araddr)
        ADDR_CONFIG: begin
          next_cur.rdata[CFG_ENABLE_BIT] = cur.bidir_reset_enable;
          next_cur.rdata[CFG_LOCKED_BIT] = cur.init_locked;
        end
        ADDR_SOURCE:  next_cur.rdata[SRC_W-1:0] = cur.source_flags;
        ADDR_COMMAND: next_cur.rdata = '0;
        ADDR_STARTUP: begin
          next_cur.rdata[PORT_W-1:0]      = cur.startup_config;
          next_cur.rdata[STARTUP_BOOT_BIT] = cur.bootstrap_mode;
        end
        ADDR_STATUS:  next_cur.rdata[EV_W-1:0] = cur.irq_status;
        ADDR_MASK:    next_cur.rdata[EV_W-1:0] = cur.irq_mask;
        default: begin
          next_cur.rresp = RESP_SLVERR;
        end
      endcase
    end

    // reset requests are only taken outside a running sequence
    hw_req  = pin_low;
    trigger = (cur.state == ST_INIT || cur.state == ST_RUN) &&
              (hw_req || sw_req || wdt_reset_req);

    case (cur.state)
      ST_SEQUENCE: begin
        if (cur.seq_count >= SEQ_LAST) begin
          next_cur.pin_drive = 1'b0;
          next_cur.hw_long   = cur.cause_hw && (pin_low || cur.hw_long);
          next_cur.state     = ST_RELEASE;
        end else begin
          next_cur.seq_count = cur.seq_count + SEQ_W'(1);
          // without our own drive, a pin still low marks a long pulse
          if (cur.cause_hw && !cur.bidir_active && pin_low) begin
            next_cur.hw_long = 1'b1;
          end
        end
      end
      ST_RELEASE: begin
        // an outside supervisor still holding the line extends the reset
        if (!pin_low && !cur.pin_drive) begin
          next_cur.state        = ST_INIT;
          next_cur.core_reset_n = 1'b1;
          ev_set[EV_RESET_DONE_BIT] = 1'b1;
          next_cur.source_flags = '0;
          if (cur.bidir_active) begin
            next_cur.source_flags[SRC_LONG_HW_BIT] = 1'b1;
          end else begin
            next_cur.source_flags[SRC_LONG_HW_BIT]  = cur.cause_hw && cur.hw_long;
            next_cur.source_flags[SRC_SHORT_HW_BIT] = cur.cause_hw && !cur.hw_long;
            next_cur.source_flags[SRC_SW_BIT]       = cur.cause_sw;
            next_cur.source_flags[SRC_WDT_BIT]      = cur.cause_wdt;
          end
          if (cur.bidir_active || cur.cause_hw) begin
            next_cur.startup_config = startup_config_port;
            next_cur.bootstrap_mode = !startup_config_port[BOOT_STRAP_BIT];
          end else begin
            next_cur.bootstrap_mode = 1'b0;
          end
        end
      end
      ST_INIT: begin
        if (end_of_init_instruction_req && !trigger) begin
          next_cur.state              = ST_RUN;
          next_cur.reset_indication_n = 1'b1;
          next_cur.init_locked        = 1'b1;
          ev_set[EV_INIT_DONE_BIT]    = 1'b1;
        end
      end
      ST_RUN: begin
        next_cur.state = ST_RUN;
      end
      default: begin
        next_cur.state = ST_SEQUENCE;
      end
    endcase

    // a reset request overrides a config write in the same cycle
    if (trigger) begin
      next_cur.state        = ST_SEQUENCE;
      next_cur.seq_count    = '0;
      next_cur.bidir_active = cur.bidir_reset_enable;
      next_cur.pin_drive    = cur.bidir_reset_enable;
      next_cur.bidir_reset_enable = 1'b0;
      next_cur.init_locked  = 1'b0;
      next_cur.cause_hw     = hw_req;
      next_cur.cause_sw     = !hw_req && sw_req;
      next_cur.cause_wdt    = !hw_req && !sw_req && wdt_reset_req;
      next_cur.hw_long      = 1'b0;
      next_cur.core_reset_n = 1'b0;
      next_cur.reset_indication_n = 1'b0;
      ev_set[EV_WDT_BIT]    = !hw_req && !sw_req && wdt_reset_req;
    end

    // set wins over a write-one clear in the same cycle
    next_cur.irq_status = (cur.irq_status & ~ev_clr) | ev_set;
    next_cur.irq        = |(next_cur.irq_status & next_cur.irq_mask);

    // ready flags are registered so every output but the tied-low pin out leaves a flip-flop
    next_cur.awready = !next_cur.aw_held && !next_cur.bvalid;
    next_cur.wready  = !next_cur.w_held && !next_cur.bvalid;
    next_cur.arready = !next_cur.rvalid;
  end

  // bus reset starts a power-on style hardware reset sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur                    <= '0;
      cur.state              <= ST_SEQUENCE;
      cur.cause_hw           <= 1'b1;
      cur.hw_long            <= 1'b1;
      cur.source_flags       <= SRC_RESET;
      cur.startup_config     <= PORT_RESET;
      cur.irq_mask           <= MASK_RESET;
      cur.bresp              <= RESP_OKAY;
      cur.rresp              <= RESP_OKAY;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register, except the tied-low pin out
  assign s_axi_awready             = cur.awready;
  assign s_axi_wready              = cur.wready;
  assign s_axi_bvalid              = cur.bvalid;
  assign s_axi_bresp               = cur.bresp;
  assign s_axi_arready             = cur.arready;
  assign s_axi_rvalid              = cur.rvalid;
  assign s_axi_rdata               = cur.rdata;
  assign s_axi_rresp               = cur.rresp;
  assign reset_input_pin_out       = 1'b0;  // open drain: only ever pulls low
  assign reset_input_pin_oe        = cur.pin_drive;
  assign reset_indication_output_n = cur.reset_indication_n;
  assign core_reset_n              = cur.core_reset_n;
  assign bootstrap_mode            = cur.bootstrap_mode;
  assign irq                       = cur.irq;

endmodule
`default_nettype wire

// *** bidir_reset_control_properties.sv ***
// Purpose: port-level checks on the bidirectional reset sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes:   sequence length is handed down through the bind
`timescale 1ns/1ps
`default_nettype none
module bidir_reset_control_checker #(
  parameter int SEQ_CYCLES = reset_ctrl_pkg::SEQ_CYCLES_DEF
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       reset_input_pin_in,
  input wire logic       reset_input_pin_out,
  input wire logic       reset_input_pin_oe,
  input wire logic       reset_indication_output_n,
  input wire logic       core_reset_n
);
  logic [15:0] oe_run;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // length of the current pull on the pin, cleared as soon as it ends
  always_ff @(posedge aclk) begin
    if (!aresetn || !reset_input_pin_oe) begin
      oe_run <= 16'h0000;
    end else begin
      oe_run <= oe_run + 16'h0001;
    end
  end
  // a long low level on the pin while the core runs must trip a reset
  sequence pin_held_low;
    (!reset_input_pin_in && core_reset_n) [*6];
  endsequence
  sequence core_goes_low;
    ##[0:3] !core_reset_n;
  endsequence
  oe_length_a: assert property ($fell(reset_input_pin_oe) |-> oe_run == 16'(SEQ_CYCLES))
    else $error("pin pull length wrong");
  oe_core_a: assert property (reset_input_pin_oe |-> !core_reset_n)
    else $error("pin pulled while core runs");
  drive_low_a: assert property (1'b1 |-> !reset_input_pin_out)
    else $error("pin driven high");
  ind_core_a: assert property (!core_reset_n |-> !reset_indication_output_n)
    else $error("indication high during reset");
  ind_rise_a: assert property ($rose(reset_indication_output_n) |-> $past(core_reset_n))
    else $error("indication released before core");
  core_rise_a: assert property ($rose(core_reset_n) |-> $past(reset_input_pin_in, 2))
    else $error("core released with pin low");
  hw_trip_a: assert property (pin_held_low |-> core_goes_low)
    else $error("long pin pulse ignored");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind bidir_reset_control bidir_reset_control_checker #(.SEQ_CYCLES(SEQ_CYCLES)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .reset_input_pin_in(reset_input_pin_in), .reset_input_pin_out(reset_input_pin_out),
  .reset_input_pin_oe(reset_input_pin_oe), .core_reset_n(core_reset_n),
  .reset_indication_output_n(reset_indication_output_n));
`default_nettype wire

// *** reset_supervisor_model.sv ***
// Purpose: external reset supervisor sharing the reset line
// Assumes: pulse length counted in aclk cycles, line has a pull-up
// Notes:   only ever pulls low or lets go, never drives high
`timescale 1ns/1ps
`default_nettype none
module reset_supervisor_model (
  // clock
  input  wire logic       aclk,
  // pulse request
  input  wire logic       start,
  input  wire logic [7:0] len,
  // open-drain pull
  output logic            pull_low
);
  logic [7:0] left;
  initial left = 8'h00;
  // pulse length
  // plain always: the counter has no reset pin, so the initial block sets it too
  always @(posedge aclk) begin
    if (start) begin
      left <= len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign pull_low = (left != 8'h00);
endmodule
`default_nettype wire

// *** bidir_reset_control_tb.sv ***
// Purpose: self-checking bench for the bidirectional reset sequencer
// Assumes: short sequence parameter, supervisor model on the line
// Notes:   lfsr from 42 picks port straps and reset causes
`timescale 1ns/1ps
`default_nettype none
module bidir_reset_control_tb;
  import reset_ctrl_pkg::*;
  localparam int SEQ = 8;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pin_in, pin_out, pin_oe, ind_n;
  logic        core_n, boot, wdt_req, irq, sup_go, sup_low;
  logic [7:0]  awaddr, araddr, sup_len;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] port, lfsr_q;
  int          fail_count, total_checks, cycles, oe_cycles;

  bidir_reset_control #(.SEQ_CYCLES(SEQ)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .reset_input_pin_in(pin_in),
    .reset_input_pin_out(pin_out), .reset_input_pin_oe(pin_oe),
    .reset_indication_output_n(ind_n), .core_reset_n(core_n),
    .startup_config_port(port), .bootstrap_mode(boot), .wdt_reset_req(wdt_req), .irq(irq));
  reset_supervisor_model sup (.aclk(aclk), .start(sup_go), .len(sup_len), .pull_low(sup_low));

  // pull-up wins unless somebody pulls the line low
  assign pin_in = !((pin_oe && !pin_out) || sup_low);

  // clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // cycle ceiling and count of cycles the device pulls the pin
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (pin_oe === 1'b1) oe_cycles = oe_cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // bidir mode always reports a long hardware reset
  function automatic logic [31:0] exp_source(input logic bidir, input int cause);
    return bidir ? 32'h1 << SRC_LONG_HW_BIT : 32'h1 << cause;
  endfunction
  // any hardware cause, long or short, samples the straps as well
  function automatic logic exp_boot(input logic bidir, input int cause, input logic [15:0] p);
    return (bidir || cause <= SRC_SHORT_HW_BIT) ? !p[BOOT_STRAP_BIT] : 1'b0;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check(rd, exp);
  endtask
  task automatic sup_pulse(input logic [7:0] n);
    @(posedge aclk);
    sup_len <= n; sup_go <= 1'b1;
    @(posedge aclk);
    sup_go <= 1'b0;
  endtask
  // bounded wait for the core reset to reach a level
  task automatic wait_core(input logic lvl);
    int n;
    n = 0;
    while (core_n !== lvl && n < 200) begin @(posedge aclk); n++; end
    check(32'(core_n), 32'(lvl));
  endtask

  // one full reset from a given cause, then the aftermath
  task automatic run_reset(input logic bidir, input int cause);
    lfsr_q = lfsr_next(lfsr_q);
    port <= lfsr_q;
    axi_write(ADDR_CONFIG, 32'(bidir));
    oe_cycles = 0;
    case (cause)
      SRC_SW_BIT: axi_write(ADDR_COMMAND, 32'h1 << CMD_SW_RESET_BIT);
      SRC_WDT_BIT: begin @(posedge aclk); wdt_req <= 1'b1; @(posedge aclk); wdt_req <= 1'b0; end
      // five low samples just trip the filter, so the supervisor has let go of the line as the sequence starts
      default: sup_pulse(cause == SRC_SHORT_HW_BIT ? 8'h05 : 8'h06);
    endcase
    wait_core(1'b0);
    wait_core(1'b1);
    check(oe_cycles, bidir ? SEQ : 0);
    rd_chk(ADDR_SOURCE, exp_source(bidir, cause));
    rd_chk(ADDR_CONFIG, 32'h0);
    check(32'(boot), 32'(exp_boot(bidir, cause, lfsr_q)));
    if (bidir || cause <= SRC_SHORT_HW_BIT)
      rd_chk(ADDR_STARTUP, {15'h0, !lfsr_q[BOOT_STRAP_BIT], lfsr_q});
    $display("reset test done cause %0d bidir %0d", cause, bidir);
  endtask

  initial begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wdt_req = 0; sup_go = 0; sup_len = 0;
    port = 0; lfsr_q = 16'h002A; fail_count = 0; total_checks = 0; cycles = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wait_core(1'b1);
    rd_chk(ADDR_CONFIG, 32'h0);
    check(32'(ind_n), 32'h0);
    rd_chk(8'h18, 32'h0);
    check(32'(rsp), 32'(RESP_SLVERR));
    axi_write(8'h1C, 32'h1);
    check(32'(rsp), 32'(RESP_SLVERR));
    // interrupt raised, masked, cleared
    rd_chk(ADDR_STATUS, 32'h1 << EV_RESET_DONE_BIT);
    check(32'(irq), 32'h0);
    axi_write(ADDR_MASK, 32'h1 << EV_RESET_DONE_BIT);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h1);
    axi_write(ADDR_STATUS, 32'h1 << EV_RESET_DONE_BIT);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    $display("register and interrupt test done");
    // a short spike must not reset the core
    sup_pulse(8'h02);
    repeat (10) @(posedge aclk);
    check(32'(core_n), 32'h1);
    $display("spike test done");
    run_reset(1'b1, SRC_LONG_HW_BIT);
    run_reset(1'b1, SRC_SHORT_HW_BIT);
    run_reset(1'b0, SRC_SHORT_HW_BIT);
    run_reset(1'b0, SRC_LONG_HW_BIT);
    for (int b = 0; b < 2; b++) begin
      run_reset(b[0], SRC_SW_BIT);
      run_reset(b[0], SRC_WDT_BIT);
    end
    repeat (3) begin
      lfsr_q = lfsr_next(lfsr_q);
      run_reset(lfsr_q[0], lfsr_q[1] ? SRC_SW_BIT : SRC_WDT_BIT);
    end
    // lock after end of init, then a reset must clear both bits
    axi_write(ADDR_CONFIG, 32'h1);
    rd_chk(ADDR_CONFIG, 32'h1);
    axi_write(ADDR_COMMAND, 32'h1 << CMD_END_OF_INIT_INSTRUCTION_BIT);
    repeat (2) @(posedge aclk);
    check(32'(ind_n), 32'h1);
    axi_write(ADDR_CONFIG, 32'h0);
    rd_chk(ADDR_CONFIG, 32'h3);
    run_reset(1'b1, SRC_SW_BIT);
    close_out();
  end
endmodule
`default_nettype wire
